// [design/srg_frame_defs.vh]
`ifndef SRG_FRAME_DEFS_VH
`define SRG_FRAME_DEFS_VH

// ==========================================================
// register byte offsets
`define OFS_PIN_CONTROL 8'h00
`define OFS_RATE_GEN_HI 8'h04
`define OFS_RATE_GEN_LO 8'h08
`define OFS_GEN_CONTROL 8'h0c
`define OFS_TX_WORD 8'h10
`define OFS_STATUS 8'h14

// ==========================================================
// pin_control_reg fields
`define PCR_RX_CLK_POL 0
`define PCR_TX_CLK_POL 1
`define PCR_RX_FS_POL 2
`define PCR_TX_FS_POL 3
`define PCR_RX_CLK_DIR 8
`define PCR_TX_CLK_DIR 9
`define PCR_RX_FS_DIR 10
`define PCR_TX_FS_DIR 11

// ==========================================================
// rate_gen_config_hi fields
`define RGH_PER_MSB 11
`define RGH_FS_FROM_SRG 12
`define RGH_SYNC_EXT 15

// rate_gen_config_lo fields
`define RGL_DIV_MSB 7
`define RGL_WID_LSB 8
`define RGL_WID_MSB 15

// gen_control fields
`define GC_SRG_RESET_N 0
`define GC_STOP_LSB 1
`define GC_STOP_MSB 2

// status fields
`define ST_RX_WORD_MSB 15
`define ST_FRAME_PULSE 16
`define ST_SRG_CLOCK 17
`define ST_SPI_MASTER 18
`define ST_SPI_SLAVE 19

// ==========================================================
// reset values and widths
`define PCR_RESET 12'h000
`define RGH_RESET 16'h0000
`define RGL_RESET 16'h0000
`define GC_RESET 3'h0
`define PER_W 12
`define WID_W 8
`define DIV_W 8
`define WORD_W 16
`define DIV_RESET 8'h01

`endif

// [design/srg_frame_and_tx_clock_config.v]
// Overview of operation
// - frame start spacing is period field plus one
// - external sync ignores the period field
// - pulse active for width field plus one
// - period and width load independent down-counters
// - pulse inactive after reset, runs when enabled
// - width count zero drops the pulse
// - period count zero starts a new frame
// - direction zero takes transmit clock from pin
// - direction one drives generated clock on pin
// - sync setting aligns generator to receive frames
// - clock stop mode: master or slave by direction
// - polarity bit picks transmit pin edge
// - input syncs and data sampled on falling edges
// - output syncs and data launched on rising edges
// - active-low input syncs inverted when polarity set
// - output syncs inverted when polarity set, sync zero
// - external transmit clock inverted when polarity set
// - driven transmit clock inverted when polarity set
// - external receive clock inverted when polarity set
// - driven receive clock inverted when polarity set
// - shared clock: equal polarities, opposite edges
// - generator reset holds clock and pulse low
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "srg_frame_defs.vh"

module srg_frame_and_tx_clock_config (
  input wire clk_i,
  input wire rst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  input wire tx_clock_pin_i,
  output reg tx_clock_pin_o,
  output reg tx_clock_pin_oe_o,
  input wire rx_clock_pin_i,
  output reg rx_clock_pin_o,
  output reg rx_clock_pin_oe_o,
  input wire tx_frame_sync_i,
  output reg tx_frame_sync_o,
  output reg tx_frame_sync_oe_o,
  input wire rx_frame_sync_i,
  output reg rx_frame_sync_o,
  output reg rx_frame_sync_oe_o,
  output reg serial_out_o,
  input wire serial_in_i
);

  // ==========================================================
  // generator states
  localparam [2:0] GEN_HOLD = 3'b001;
  localparam [2:0] GEN_PULSE = 3'b010;
  localparam [2:0] GEN_GAP = 3'b100;

  // ==========================================================
  // configuration
  reg [11:0] pin_control_reg;
  reg [15:0] rate_gen_config_hi;
  reg [15:0] rate_gen_config_lo;
  reg [2:0] gen_control;
  reg [`WORD_W-1:0] tx_word;
  reg tx_word_fresh;

  wire rx_clk_pol = pin_control_reg[`PCR_RX_CLK_POL];
  wire tx_clk_pol = pin_control_reg[`PCR_TX_CLK_POL];
  wire rx_fs_pol = pin_control_reg[`PCR_RX_FS_POL];
  wire tx_fs_pol = pin_control_reg[`PCR_TX_FS_POL];
  wire rx_clk_dir = pin_control_reg[`PCR_RX_CLK_DIR];
  wire tx_clk_dir = pin_control_reg[`PCR_TX_CLK_DIR];
  wire rx_fs_dir = pin_control_reg[`PCR_RX_FS_DIR];
  wire tx_fs_dir = pin_control_reg[`PCR_TX_FS_DIR];
  wire [`PER_W-1:0] frame_period_field = rate_gen_config_hi[`RGH_PER_MSB:0];
  wire tx_fs_from_srg = rate_gen_config_hi[`RGH_FS_FROM_SRG];
  wire sync_to_external = rate_gen_config_hi[`RGH_SYNC_EXT];
  wire [`DIV_W-1:0] clk_div = rate_gen_config_lo[`RGL_DIV_MSB:0];
  wire [`WID_W-1:0] frame_width_field = rate_gen_config_lo[`RGL_WID_MSB:`RGL_WID_LSB];
  wire srg_reset_n = gen_control[`GC_SRG_RESET_N];
  wire [1:0] clock_stop_sel = gen_control[`GC_STOP_MSB:`GC_STOP_LSB];

  // ==========================================================
  // clock stop mode role
  wire spi_mode = clock_stop_sel[1];
  wire spi_master = spi_mode & tx_clk_dir;
  wire spi_slave = spi_mode & ~tx_clk_dir;

  // ==========================================================
  // apb slave, one wait state per transfer
  wire apb_setup_done = psel_i & penable_i & ~pready_o;
  wire apb_commit = psel_i & penable_i & pready_o;

  function addr_known;
    input [7:0] a;
    begin
      addr_known = (a == `OFS_PIN_CONTROL) || (a == `OFS_RATE_GEN_HI) ||
                   (a == `OFS_RATE_GEN_LO) || (a == `OFS_GEN_CONTROL) ||
                   (a == `OFS_TX_WORD) || (a == `OFS_STATUS);
    end
  endfunction

  // ==========================================================
  // generated clock and frame pulse
  reg srg_clock;
  reg srg_frame_pulse;
  reg [`DIV_W-1:0] div_cnt;
  reg [`PER_W-1:0] per_cnt;
  reg [`WID_W-1:0] wid_cnt;
  reg [2:0] gen_state;
  reg sync_start;
  reg rx_fs_prev;

  // internal receive frame sync, always active high
  wire rx_fs_level = rx_frame_sync_i ^ rx_fs_pol;
  wire tx_fs_level = tx_frame_sync_i ^ tx_fs_pol;
  wire ext_frame = rx_fs_level & ~rx_fs_prev;
  wire resync = sync_to_external & ext_frame;
  wire div_wrap = (div_cnt == 8'h00);
  wire srg_tick = srg_reset_n & div_wrap & ~srg_clock & ~resync;
  wire frame_enable = srg_reset_n & tx_fs_from_srg;

  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_fs_prev <= 1'b0;
    end else begin
      rx_fs_prev <= rx_fs_level;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i || !srg_reset_n) begin
      srg_clock <= 1'b0;
      div_cnt <= `DIV_RESET;
    end else if (resync) begin
      // restart the half period so the clock lines up with the sync edge
      srg_clock <= 1'b0;
      div_cnt <= clk_div;
    end else if (div_wrap) begin
      srg_clock <= ~srg_clock;
      div_cnt <= clk_div;
    end else begin
      div_cnt <= div_cnt - 8'h01;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i || !frame_enable) begin
      gen_state <= GEN_HOLD;
      srg_frame_pulse <= 1'b0;
      per_cnt <= 12'h000;
      wid_cnt <= 8'h00;
      sync_start <= 1'b0;
    end else if (resync) begin
      // external sync replaces the period counter as frame source; the start
      // waits for the next tick so the pulse meets width plus one clock rises
      gen_state <= GEN_HOLD;
      srg_frame_pulse <= 1'b0;
      sync_start <= 1'b1;
    end else if (srg_tick) begin
      case (gen_state)
        GEN_HOLD: begin
          if (!sync_to_external || sync_start) begin
            gen_state <= GEN_PULSE;
            srg_frame_pulse <= 1'b1;
            per_cnt <= frame_period_field;
            wid_cnt <= frame_width_field;
            sync_start <= 1'b0;
          end
        end
        GEN_PULSE: begin
          if (per_cnt == 12'h000 && !sync_to_external) begin
            // restart wins over width expiry, pulse stays high
            srg_frame_pulse <= 1'b1;
            per_cnt <= frame_period_field;
            wid_cnt <= frame_width_field;
          end else begin
            if (per_cnt != 12'h000) begin
              per_cnt <= per_cnt - 12'h001;
            end
            if (wid_cnt == 8'h00) begin
              srg_frame_pulse <= 1'b0;
              gen_state <= GEN_GAP;
            end else begin
              wid_cnt <= wid_cnt - 8'h01;
            end
          end
        end
        GEN_GAP: begin
          if (per_cnt == 12'h000) begin
            if (!sync_to_external) begin
              gen_state <= GEN_PULSE;
              srg_frame_pulse <= 1'b1;
              per_cnt <= frame_period_field;
              wid_cnt <= frame_width_field;
            end
          end else begin
            per_cnt <= per_cnt - 12'h001;
          end
        end
        default: begin
          gen_state <= GEN_HOLD;
          srg_frame_pulse <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // internal bit clocks and their edges
  wire tx_int_clk = tx_clk_dir ? srg_clock : (tx_clock_pin_i ^ tx_clk_pol);
  wire rx_int_clk = rx_clk_dir ? srg_clock : (rx_clock_pin_i ^ rx_clk_pol);
  reg tx_clk_prev;
  reg rx_clk_prev;
  wire tx_rise = tx_int_clk & ~tx_clk_prev;
  wire tx_fall = ~tx_int_clk & tx_clk_prev;
  wire rx_fall = ~rx_int_clk & rx_clk_prev;

  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_clk_prev <= 1'b0;
      rx_clk_prev <= 1'b0;
    end else begin
      tx_clk_prev <= tx_int_clk;
      rx_clk_prev <= rx_int_clk;
    end
  end

  // ==========================================================
  // frame syncs seen by transmitter and receiver
  reg tx_fs_int;
  reg rx_fs_int;
  reg tx_fs_gen;
  reg rx_fs_gen;
  // without the generator a fresh word asks for a two-bit-clock sync
  wire tx_fs_src = tx_fs_from_srg ? srg_frame_pulse : tx_word_fresh;

  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_fs_int <= 1'b0;
      rx_fs_int <= 1'b0;
      tx_fs_gen <= 1'b0;
      rx_fs_gen <= 1'b0;
    end else begin
      if (!tx_fs_dir && tx_fall) begin
        tx_fs_int <= tx_fs_level;
      end else if (tx_fs_dir && tx_rise) begin
        tx_fs_gen <= tx_fs_src;
        tx_fs_int <= tx_fs_src;
      end
      if (!rx_fs_dir && rx_fall) begin
        rx_fs_int <= rx_fs_level;
      end else if (rx_fs_dir && rx_int_clk && !rx_clk_prev) begin
        rx_fs_gen <= srg_frame_pulse;
        rx_fs_int <= srg_frame_pulse;
      end
    end
  end

  // ==========================================================
  // minimal shift path: launch on rising, sample on falling
  reg [`WORD_W-1:0] tx_shift;
  reg [`WORD_W-1:0] rx_shift;
  reg serial_bit;

  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_shift <= 16'h0000;
      rx_shift <= 16'h0000;
      serial_bit <= 1'b0;
    end else begin
      if (tx_rise) begin
        if (tx_fs_int) begin
          tx_shift <= {tx_word[`WORD_W-2:0], 1'b0};
          serial_bit <= tx_word[`WORD_W-1];
        end else begin
          tx_shift <= {tx_shift[`WORD_W-2:0], 1'b0};
          serial_bit <= tx_shift[`WORD_W-1];
        end
      end
      // opposite edge to the launch keeps setup and hold symmetric
      if (rx_fall) begin
        rx_shift <= {rx_shift[`WORD_W-2:0], serial_in_i};
      end
    end
  end

  // ==========================================================
  // pins, all registered
  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_clock_pin_o <= 1'b0;
      tx_clock_pin_oe_o <= 1'b0;
      rx_clock_pin_o <= 1'b0;
      rx_clock_pin_oe_o <= 1'b0;
      tx_frame_sync_o <= 1'b0;
      tx_frame_sync_oe_o <= 1'b0;
      rx_frame_sync_o <= 1'b0;
      rx_frame_sync_oe_o <= 1'b0;
      serial_out_o <= 1'b0;
    end else begin
      tx_clock_pin_o <= srg_clock ^ tx_clk_pol;
      tx_clock_pin_oe_o <= tx_clk_dir;
      rx_clock_pin_o <= srg_clock ^ rx_clk_pol;
      rx_clock_pin_oe_o <= rx_clk_dir;
      tx_frame_sync_o <= tx_fs_gen ^ (tx_fs_pol & ~sync_to_external);
      tx_frame_sync_oe_o <= tx_fs_dir;
      rx_frame_sync_o <= rx_fs_gen ^ (rx_fs_pol & ~sync_to_external);
      rx_frame_sync_oe_o <= rx_fs_dir;
      serial_out_o <= serial_bit;
    end
  end

  // ==========================================================
  // register file
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_control_reg <= `PCR_RESET;
      rate_gen_config_hi <= `RGH_RESET;
      rate_gen_config_lo <= `RGL_RESET;
      gen_control <= `GC_RESET;
      tx_word <= 16'h0000;
      tx_word_fresh <= 1'b0;
    end else begin
      // the sync consumes the fresh word; a new write in that cycle wins
      if (tx_rise && tx_fs_int) begin
        tx_word_fresh <= 1'b0;
      end
      if (apb_commit && pwrite_i) begin
        case (paddr_i)
          `OFS_PIN_CONTROL: pin_control_reg <= pwdata_i[11:0];
          `OFS_RATE_GEN_HI: rate_gen_config_hi <= pwdata_i[15:0];
          `OFS_RATE_GEN_LO: rate_gen_config_lo <= pwdata_i[15:0];
          `OFS_GEN_CONTROL: gen_control <= pwdata_i[2:0];
          `OFS_TX_WORD: begin
            tx_word <= pwdata_i[15:0];
            tx_word_fresh <= 1'b1;
          end
          default: begin
            tx_word_fresh <= tx_word_fresh & ~(tx_rise & tx_fs_int);
          end
        endcase
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end else if (apb_setup_done) begin
      pready_o <= 1'b1;
      pslverr_o <= ~addr_known(paddr_i);
      // writes leave the last read answer standing
      if (!pwrite_i) begin
        case (paddr_i)
          `OFS_PIN_CONTROL: prdata_o <= {20'h00000, pin_control_reg};
          `OFS_RATE_GEN_HI: prdata_o <= {16'h0000, rate_gen_config_hi};
          `OFS_RATE_GEN_LO: prdata_o <= {16'h0000, rate_gen_config_lo};
          `OFS_GEN_CONTROL: prdata_o <= {29'h0, gen_control};
          `OFS_TX_WORD: prdata_o <= {16'h0000, tx_word};
          `OFS_STATUS: prdata_o <= {12'h000, spi_slave, spi_master, srg_clock,
                                    srg_frame_pulse, rx_shift};
          default: prdata_o <= 32'h00000000;
        endcase
      end
    end else begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

endmodule

// [verification/srg_serial_peer.sv]
`timescale 1ns/1ps
// ========
// external serial device
module srg_serial_peer (
  input wire clk_i,
  input wire run_i,
  output reg bit_clk_o,
  output wire tx_fs_o,
  output wire rx_fs_o,
  output wire data_o
);
  integer cnt = 0;
  // one bit clock feeds both directions, still between runs
  always @(posedge clk_i) begin
    if (!run_i) begin
      cnt <= 0;
      bit_clk_o <= 1'h0;
    end else begin
      cnt <= (cnt == 39) ? 0 : cnt + 1;
      if (cnt % 5 == 4) bit_clk_o <= ~bit_clk_o;
    end
  end
  assign tx_fs_o = run_i && cnt < 10;
  assign rx_fs_o = run_i && cnt < 2;
  // no pull on the data line, so keep it moving
  assign data_o = cnt[0] ^ cnt[3];
endmodule

// [verification/srg_frame_asserts.sv]
`timescale 1ns/1ps
// ========
// port checker
module srg_frame_asserts (
  input wire clk_i,
  input wire rst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  input wire tx_clock_pin_oe_o,
  input wire rx_clock_pin_oe_o,
  input wire tx_frame_sync_oe_o,
  input wire serial_out_o
);
  reg wr_d1;
  reg wr_d2;
  // enables may lag the write by a register stage
  always @(posedge clk_i) begin
    wr_d1 <= pready_o && pwrite_i;
    wr_d2 <= wr_d1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_reset_quiet: assert property ($fell(rst_i) |->
    !(tx_clock_pin_oe_o || rx_clock_pin_oe_o || tx_frame_sync_oe_o || serial_out_o))
    else $error("outputs active after reset");
  chk_ready_wait: assert property (psel_i && !penable_i |=> !pready_o ##1 pready_o)
    else $error("ready not on second access cycle");
  chk_ready_single: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  chk_err_with_ready: assert property (pslverr_o |-> pready_o && psel_i && penable_i)
    else $error("error outside an answer");
  chk_rdata_hold: assert property ($changed(prdata_o) |-> pready_o && !pwrite_i)
    else $error("read data moved without a read");
  chk_txclk_oe_write: assert property ($changed(tx_clock_pin_oe_o) |-> wr_d1 || wr_d2)
    else $error("transmit clock enable moved without a write");
  chk_rxclk_oe_write: assert property ($changed(rx_clock_pin_oe_o) |-> wr_d1 || wr_d2)
    else $error("receive clock enable moved without a write");
  chk_txfs_oe_write: assert property ($changed(tx_frame_sync_oe_o) |-> wr_d1 || wr_d2)
    else $error("frame sync enable moved without a write");
endmodule

bind srg_frame_and_tx_clock_config srg_frame_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .tx_clock_pin_oe_o(tx_clock_pin_oe_o),
  .rx_clock_pin_oe_o(rx_clock_pin_oe_o), .tx_frame_sync_oe_o(tx_frame_sync_oe_o),
  .serial_out_o(serial_out_o));

// [verification/srg_frame_and_tx_clock_config_bench.sv]
`timescale 1ns/1ps
module srg_frame_and_tx_clock_config_bench;
  reg clk_i = 1'h0;
  reg rst_i = 1'h1;
  reg psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0, run = 1'h0;
  reg mon = 1'h0, pol_r = 1'h0, last_ck = 1'h0, last_so = 1'h0, er;
  reg [7:0] paddr_i = 8'h0;
  reg [31:0] pwdata_i = 32'h0, rd, v;
  wire [31:0] prdata_o;
  wire pready_o, pslverr_o, tck, tfs, rfs, sdi, tco, tce, rco, rce, tfo, tfe, rfo, rfe, sdo;
  wire tx_ck_w = tce ? tco : tck;
  wire rx_ck_w = rce ? rco : tck;
  wire tx_fs_w = tfe ? tfo : tfs;
  wire rx_fs_w = rfe ? rfo : rfs;
  integer err_total = 0, cmp_count = 0, seed = 12630, i, n, hi, lo, since = 0, moves = 0;
  always #10 clk_i = ~clk_i;
  srg_serial_peer u_peer (.clk_i(clk_i), .run_i(run), .bit_clk_o(tck), .tx_fs_o(tfs),
    .rx_fs_o(rfs), .data_o(sdi));
  srg_frame_and_tx_clock_config u_dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .tx_clock_pin_i(tx_ck_w), .tx_clock_pin_o(tco), .tx_clock_pin_oe_o(tce),
    .rx_clock_pin_i(rx_ck_w), .rx_clock_pin_o(rco), .rx_clock_pin_oe_o(rce),
    .tx_frame_sync_i(tx_fs_w), .tx_frame_sync_o(tfo), .tx_frame_sync_oe_o(tfe),
    .rx_frame_sync_i(rx_fs_w), .rx_frame_sync_o(rfo), .rx_frame_sync_oe_o(rfe),
    .serial_out_o(sdo), .serial_in_i(sdi));
  // ========
  // checking and closing
  task complete_run;
    $display("compared %0d, failed %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %0s expected %h seen %h", nm, e, g);
    end
  endtask
  task stop_hang(input string nm);
    err_total++;
    $display("CHECK FAILED %0s expected done seen timeout", nm);
    complete_run;
  endtask
  function integer ticks(input integer f, input integer d);
    ticks = (f + 1) * 2 * (d + 1);
  endfunction
  // ========
  // apb master, request held until pready
  task apb(input w, input [7:0] a, input [31:0] d);
    integer k;
    @(posedge clk_i);
    psel_i <= 1'h1;
    penable_i <= 1'h0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'h1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'h1 && k < 20);
    if (k >= 20) stop_hang("pready");
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask
  task wait_fs(input lvl, input integer lim, output integer c);
    c = 0;
    while (tfo !== lvl && c < lim) begin
      @(posedge clk_i);
      c++;
    end
    if (c >= lim) stop_hang("frame sync");
  endtask
  // ========
  // generated frame measured on the sync pin
  task frame(input integer p, input integer w, input integer d, input pol);
    apb(1'h1, 8'h0c, 32'h0);
    apb(1'h1, 8'h08, {w[7:0], d[7:0]});
    apb(1'h1, 8'h04, 32'h1000 | p[11:0]);
    apb(1'h1, 8'h00, 32'h0a00 | {pol, 3'h0});
    apb(1'h1, 8'h0c, 32'h1);
    wait_fs(~pol, 3 * ticks(p, d) + 200, n);
    if (w >= p) begin
      hi = 0;
      repeat (300) begin
        @(posedge clk_i);
        if (tfo !== ~pol) hi++;
      end
      chk("held pulse", 0, hi);
    end else begin
      // skip the first pulse: a sync left from the last run may merge with it
      wait_fs(pol, ticks(p, d) + 20, n);
      wait_fs(~pol, ticks(p, d) + 20, n);
      repeat (2) begin
        wait_fs(pol, ticks(w, d) + 20, hi);
        wait_fs(~pol, ticks(p, d) + 20, lo);
        chk("width", ticks(w, d), hi);
        chk("period", ticks(p, d), hi + lo);
      end
    end
    $display("frame %0d/%0d done", p, w);
  endtask
  // serial out may move only just after an active pin edge
  always @(posedge clk_i) begin
    if (((tx_ck_w ^ pol_r) & ~(last_ck ^ pol_r)) == 1'h1) since <= 0;
    else since <= since + 1;
    last_ck <= tx_ck_w;
    last_so <= sdo;
    if (mon && sdo !== last_so) begin
      moves <= moves + 1;
      chk("tx edge", 1, since <= 3);
    end
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    for (i = 0; i < 4; i++) if (i != 2) begin
      apb(1'h0, {i[5:0], 2'h0}, 32'h0);
      chk("reset value", 0, rd);
    end
    apb(1'h0, 8'h18, 32'h0);
    chk("unmapped err", 1, er);
    chk("unmapped data", 0, rd);
    v = $random(seed);
    apb(1'h1, 8'h00, v);
    apb(1'h0, 8'h00, 32'h0);
    chk("pin control", v & 32'h0fff, rd);
    $display("registers done");
    apb(1'h1, 8'h0c, 32'h0);
    for (i = 0; i < 16; i++) begin
      apb(1'h1, 8'h00, {i[3:2], 6'h0, i[1:0]});
      repeat (3) @(posedge clk_i);
      chk("tx pin", {i[3], i[3] & i[1]}, {tce, tco & tce});
      chk("rx pin", {i[2], i[2] & i[0]}, {rce, rco & rce});
    end
    for (i = 0; i < 8; i++) begin
      apb(1'h1, 8'h00, {i[2], 9'h0});
      apb(1'h1, 8'h0c, {i[1:0], 1'h0});
      apb(1'h0, 8'h14, 32'h0);
      chk("spi role", {i[1] & ~i[2], i[1] & i[2]}, rd[19:18]);
    end
    $display("pin modes done");
    frame(15, 1, 0, 1'h1);
    frame(1, 0, 0, 1'h0);
    frame(0, 0, 0, 1'h0);
    frame(7, 9, 1, 1'h0);
    frame(4095, 255, 0, 1'h0);
    for (i = 0; i < 6; i++) begin
      n = 1 + {$random(seed)} % 30;
      frame(n, {$random(seed)} % n, {$random(seed)} % 2, 1'h0);
    end
    apb(1'h1, 8'h0c, 32'h0);
    apb(1'h1, 8'h04, 32'h9005);
    apb(1'h1, 8'h08, 32'h0);
    apb(1'h1, 8'h0c, 32'h1);
    run <= 1'h1;
    repeat (60) @(posedge clk_i);
    wait_fs(1'h0, 100, n);
    wait_fs(1'h1, 100, n);
    wait_fs(1'h0, 100, hi);
    wait_fs(1'h1, 100, lo);
    chk("ext width", ticks(0, 0), hi);
    chk("ext period", 40, hi + lo);
    run <= 1'h0;
    $display("external sync done");
    for (i = 0; i < 2; i++) begin
      apb(1'h1, 8'h00, {i[0], 1'h0});
      // top bits 01 make the first two bits differ, so the pin must move
      v = $random(seed);
      apb(1'h1, 8'h10, {v[31:16], 2'h1, v[13:0]});
      moves = 0;
      pol_r <= i[0];
      mon <= 1'h1;
      run <= 1'h1;
      repeat (200) @(posedge clk_i);
      mon <= 1'h0;
      run <= 1'h0;
      chk("tx moved", 1, moves > 0);
    end
    $display("external clock done");
    frame(3, 1, 0, 1'h0);
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    apb(1'h0, 8'h0c, 32'h0);
    chk("gen after reset", 0, rd);
    chk("pins after reset", 0, {tce, tfe, tfo});
    $display("second reset done");
    complete_run;
  end
endmodule
